// File: design/swpc_device.sv
// swpc_device: standby sequencer, wake sources and pad control
// assumes: link registers written by external processor or firmware;
// wake pins synchronous to i_clk; core clock gating done outside
//
// Added by the designer: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module swpc_device #(
	parameter int unsigned CTL_W = swpc_pkg::CTL_W,
	parameter int unsigned SER_W = swpc_pkg::SER_W
) (
	input  wire logic             i_clk,
	input  wire logic             i_rst_n,
	swpc_if.dev                   lnk,
	input  wire logic             i_fw_wr,
	input  wire logic [3:0]       i_fw_addr,
	input  wire logic [31:0]      i_fw_wdata,
	input  wire logic             i_vbus_det,
	input  wire logic             i_uart_cts,
	input  wire logic             i_ctl_in,
	input  wire logic [CTL_W-1:0] i_ctl_pin,
	input  wire logic [SER_W-1:0] i_ser_pin,
	output logic                  o_osc_en,
	output logic                  o_pll_en,
	output logic                  o_xcvr_en,
	output logic                  o_core_pwr_en,
	output logic                  o_cpu_pc_rst,
	output logic                  o_standby,
	output logic                  o_pad_hold,
	output logic [7:0]            o_pull_mode,
	output logic [7:0]            o_drive_sel,
	output logic [CTL_W-1:0]      o_ctl_oe,
	output logic [CTL_W-1:0]      o_ctl_out,
	output logic [SER_W-1:0]      o_ser_oe,
	output logic [SER_W-1:0]      o_ser_out
);
	import swpc_pkg::*;

	// ------------------------------------------------------------
	// registers (held through standby while o_core_pwr_en powers the core down)
	// ------------------------------------------------------------
	logic             cts_pol_ff;
	logic [3:0]       wake_src_ff;
	logic [7:0]       pull_ff;
	logic [7:0]       drive_ff;
	logic [CTL_W-1:0] ctl_gpio_ff;
	logic [CTL_W-1:0] ctl_dir_ff;
	logic [CTL_W-1:0] ctl_out_ff;
	logic [SER_W-1:0] ser_gpio_ff;
	logic [SER_W-1:0] ser_dir_ff;
	logic [SER_W-1:0] ser_out_ff;
	logic [31:0]      rdata_ff;
	logic             boot_ff;
	swpc_pwr_type     pwr_ff;
	swpc_pwr_type     nxt_pwr;

	// either writer may reach the registers; processor link wins a clash
	logic        wr;
	logic [3:0]  wa;
	logic [31:0] wd;
	assign wr = lnk.wr | i_fw_wr;
	assign wa = lnk.wr ? lnk.addr : i_fw_addr;
	assign wd = lnk.wr ? lnk.wdata : i_fw_wdata;

	logic       enter_req;
	logic [3:0] wake_hit;
	assign enter_req = wr && (wa == REG_CTRL) && wd[CTRL_STANDBY];
	assign wake_hit  = {1'b0, i_ctl_in, i_uart_cts == cts_pol_ff, i_vbus_det};

	// ------------------------------------------------------------
	// power sequencer
	// ------------------------------------------------------------
	always_comb begin
		nxt_pwr = pwr_ff;
		case (pwr_ff)
			PWR_RUN:     if (enter_req) nxt_pwr = PWR_ENTER;
			PWR_ENTER:   nxt_pwr = PWR_STANDBY;
			PWR_STANDBY: if (|wake_hit) nxt_pwr = PWR_WAKE;
			PWR_WAKE:    nxt_pwr = PWR_RUN;
			default:     nxt_pwr = PWR_RUN;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pwr_ff <= PWR_RUN;
		end else begin
			pwr_ff <= nxt_pwr;
		end
	end

	// power switches are registered so pins never glitch
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_osc_en      <= 1'b1;
			o_pll_en      <= 1'b1;
			o_xcvr_en     <= 1'b1;
			o_core_pwr_en <= 1'b1;
			o_standby     <= 1'b0;
			o_pad_hold    <= 1'b0;
			o_cpu_pc_rst  <= 1'b1;
		end else begin
			o_osc_en      <= (nxt_pwr == PWR_RUN) || (nxt_pwr == PWR_WAKE);
			o_pll_en      <= (nxt_pwr == PWR_RUN) || (nxt_pwr == PWR_WAKE);
			o_xcvr_en     <= (nxt_pwr == PWR_RUN) || (nxt_pwr == PWR_WAKE);
			o_core_pwr_en <= (nxt_pwr == PWR_RUN) || (nxt_pwr == PWR_WAKE);
			o_standby     <= (nxt_pwr == PWR_STANDBY);
			o_pad_hold    <= (nxt_pwr == PWR_ENTER) || (nxt_pwr == PWR_STANDBY);
			// one-cycle program counter reset on the way out, also after reset
			o_cpu_pc_rst  <= (nxt_pwr == PWR_WAKE) || boot_ff;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			boot_ff <= 1'b1;
		end else begin
			boot_ff <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// wake source capture
	// ------------------------------------------------------------
	// reset wake is only knowable after the fact: flagged at power-up
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wake_src_ff <= 4'h8;
		end else if (pwr_ff == PWR_STANDBY && |wake_hit) begin
			wake_src_ff <= wake_hit;
		end else if (enter_req) begin
			wake_src_ff <= 4'h0;
		end
	end

	// ------------------------------------------------------------
	// configuration registers, untouched by standby
	// ------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cts_pol_ff  <= 1'b0;
			pull_ff     <= RST_PULL;
			drive_ff    <= RST_DRIVE;
			ctl_gpio_ff <= '0;
			ctl_dir_ff  <= '0;
			ctl_out_ff  <= '0;
			ser_gpio_ff <= '0;
			ser_dir_ff  <= '0;
			ser_out_ff  <= '0;
		end else if (wr) begin
			case (wa)
				REG_CTRL:     cts_pol_ff  <= wd[CTRL_CTS_POL];
				REG_PULL:     pull_ff     <= wd[7:0];
				REG_DRIVE:    drive_ff    <= wd[7:0];
				REG_CTL_GPIO: ctl_gpio_ff <= wd[CTL_W-1:0];
				REG_CTL_DIR:  ctl_dir_ff  <= wd[CTL_W-1:0];
				REG_CTL_OUT:  ctl_out_ff  <= wd[CTL_W-1:0];
				REG_SER_GPIO: ser_gpio_ff <= wd[SER_W-1:0];
				REG_SER_DIR:  ser_dir_ff  <= wd[SER_W-1:0];
				REG_SER_OUT:  ser_out_ff  <= wd[SER_W-1:0];
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------
	// pad drive; outputs freeze while held
	// ------------------------------------------------------------
	logic [CTL_W-1:0] ctl_gpio_ok;
	genvar g;
	generate
		for (g = 0; g < CTL_W; g++) begin : g_ctl
			// the top control line is never released to software
			assign ctl_gpio_ok[g] = (g == CTL_SPARE) ? 1'b0 : ctl_gpio_ff[g];
		end
	endgenerate

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_pull_mode <= RST_PULL;
			o_drive_sel <= RST_DRIVE;
			o_ctl_oe    <= '0;
			o_ctl_out   <= '0;
			o_ser_oe    <= '0;
			o_ser_out   <= '0;
		end else if (!o_pad_hold) begin
			o_pull_mode <= pull_ff;
			o_drive_sel <= drive_ff;
			o_ctl_oe    <= ctl_gpio_ok & ctl_dir_ff;
			o_ctl_out   <= ctl_gpio_ok & ctl_out_ff;
			o_ser_oe    <= ser_gpio_ff & ser_dir_ff;
			o_ser_out   <= ser_gpio_ff & ser_out_ff;
		end
	end

	// ------------------------------------------------------------
	// read port
	// ------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rdata_ff <= RST_ZERO;
		end else if (lnk.rd) begin
			case (lnk.addr)
				REG_CTRL:     rdata_ff <= {30'h0, cts_pol_ff, o_standby};
				REG_WAKE_SRC: rdata_ff <= {28'h0, wake_src_ff};
				REG_PULL:     rdata_ff <= {24'h0, pull_ff};
				REG_DRIVE:    rdata_ff <= {24'h0, drive_ff};
				REG_CTL_GPIO: rdata_ff <= 32'(ctl_gpio_ok);
				REG_CTL_DIR:  rdata_ff <= 32'(ctl_dir_ff);
				REG_CTL_OUT:  rdata_ff <= 32'(ctl_out_ff);
				REG_SER_GPIO: rdata_ff <= 32'(ser_gpio_ff);
				REG_SER_DIR:  rdata_ff <= 32'(ser_dir_ff);
				REG_SER_OUT:  rdata_ff <= 32'(ser_out_ff);
				REG_PIN_IN:   rdata_ff <= 32'({i_ser_pin, i_ctl_pin});
				default:      rdata_ff <= RST_ZERO;
			endcase
		end else begin
			rdata_ff <= RST_ZERO;
		end
	end
	assign lnk.rdata = rdata_ff;

endmodule
`default_nettype wire

// File: design/swpc_pkg.sv
// swpc_pkg: shared constants for the standby wake and pad control block
// assumes: both ends compile this package first
package swpc_pkg;

	// ------------------------------------------------------------
	// geometry
	// ------------------------------------------------------------
	localparam int unsigned CTL_W     = 16;
	localparam int unsigned SER_W     = 8;
	localparam int unsigned GRP_N     = 4;
	localparam int unsigned CTL_SPARE = 15;

	// ------------------------------------------------------------
	// register offsets (device link and controller port)
	// ------------------------------------------------------------
	localparam logic [3:0] REG_CTRL      = 4'h0;
	localparam logic [3:0] REG_WAKE_SRC  = 4'h1;
	localparam logic [3:0] REG_PULL      = 4'h2;
	localparam logic [3:0] REG_DRIVE     = 4'h3;
	localparam logic [3:0] REG_CTL_GPIO  = 4'h4;
	localparam logic [3:0] REG_CTL_DIR   = 4'h5;
	localparam logic [3:0] REG_CTL_OUT   = 4'h6;
	localparam logic [3:0] REG_SER_GPIO  = 4'h7;
	localparam logic [3:0] REG_SER_DIR   = 4'h8;
	localparam logic [3:0] REG_SER_OUT   = 4'h9;
	localparam logic [3:0] REG_PIN_IN    = 4'ha;
	localparam logic [3:0] REG_IRQ_STAT  = 4'hb;
	localparam logic [3:0] REG_IRQ_MASK  = 4'hc;
	localparam logic [3:0] REG_DEV_CMD   = 4'hd;
	localparam logic [3:0] REG_DEV_RDATA = 4'he;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int unsigned CTRL_STANDBY = 0;
	localparam int unsigned CTRL_CTS_POL = 1;
	localparam int unsigned WAKE_VBUS    = 0;
	localparam int unsigned WAKE_CTS     = 1;
	localparam int unsigned WAKE_CTL0    = 2;
	localparam int unsigned WAKE_RESET   = 3;
	localparam int unsigned PULL_MODE_W  = 2;
	localparam int unsigned DRIVE_W      = 2;
	localparam int unsigned IRQ_DONE     = 0;
	localparam int unsigned IRQ_WOKE     = 1;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [31:0] RST_ZERO  = 32'h0000_0000;
	localparam logic [7:0]  RST_PULL  = 8'h55;
	localparam logic [7:0]  RST_DRIVE = 8'h00;

	typedef enum logic [1:0] {
		PULL_HIGHZ = 2'b00,
		PULL_UP    = 2'b01,
		PULL_DOWN  = 2'b10
	} swpc_pull_type;

	typedef enum logic [1:0] {
		DRV_FULL    = 2'b00,
		DRV_THREEQ  = 2'b01,
		DRV_HALF    = 2'b10,
		DRV_QUARTER = 2'b11
	} swpc_drive_type;

	typedef enum logic [1:0] {
		PWR_RUN     = 2'b00,
		PWR_ENTER   = 2'b01,
		PWR_STANDBY = 2'b10,
		PWR_WAKE    = 2'b11
	} swpc_pwr_type;

	typedef enum logic [1:0] {
		HST_IDLE = 2'b00,
		HST_WAIT = 2'b01,
		HST_TAKE = 2'b10
	} swpc_hst_type;

endpackage

// File: design/swpc_if.sv
// swpc_if: register link between the external processor and the device
// assumes: one clock; device answers reads one cycle after the strobe
`timescale 1ns/1ps
`default_nettype none
interface swpc_if;
	logic        wr;
	logic        rd;
	logic [3:0]  addr;
	logic [31:0] wdata;
	logic [31:0] rdata;

	modport dev (input wr, input rd, input addr, input wdata, output rdata);
	modport host (output wr, output rd, output addr, output wdata, input rdata);
endinterface
`default_nettype wire

// File: design/swpc_host.sv
// swpc_host: external processor end; turns controller port orders into link cycles
// assumes: software drives a plain strobe port; device answers reads next cycle
`timescale 1ns/1ps
`default_nettype none
module swpc_host (
	input  wire logic         i_clk,
	input  wire logic         i_rst_n,
	swpc_if.host              lnk,
	input  wire logic [3:0]   i_addr,
	input  wire logic [31:0]  i_wdata,
	input  wire logic         i_wr,
	input  wire logic         i_rd,
	output logic [31:0]       o_rdata,
	output logic              o_irq
);
	import swpc_pkg::*;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic        lwr_ff;
	logic        lrd_ff;
	logic [3:0]  laddr_ff;
	logic [31:0] lwd_ff;
	logic [31:0] dev_rd_ff;
	logic [1:0]  stat_ff;
	logic [1:0]  mask_ff;
	swpc_hst_type st_ff;
	logic [1:0]  ev;

	assign lnk.wr    = lwr_ff;
	assign lnk.rd    = lrd_ff;
	assign lnk.addr  = laddr_ff;
	assign lnk.wdata = lwd_ff;

	// ------------------------------------------------------------
	// link sequencer: one device access per command write taken in HST_IDLE; writes while busy are dropped
	// ------------------------------------------------------------
	logic cmd;
	assign cmd = i_wr && (i_addr == REG_DEV_CMD);

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_ff    <= HST_IDLE;
			lwr_ff   <= 1'b0;
			lrd_ff   <= 1'b0;
			laddr_ff <= 4'h0;
			lwd_ff   <= RST_ZERO;
		end else begin
			lwr_ff <= 1'b0;
			lrd_ff <= 1'b0;
			case (st_ff)
				HST_IDLE: if (cmd) begin
					// bit 8 selects read; low nibble is device offset
					// buffers must already be drained before a standby write
					laddr_ff <= i_wdata[3:0];
					lwd_ff   <= {16'h0, i_wdata[31:16]};
					lwr_ff   <= ~i_wdata[8];
					lrd_ff   <= i_wdata[8];
					st_ff    <= i_wdata[8] ? HST_WAIT : HST_IDLE;
				end
				HST_WAIT: st_ff <= HST_TAKE;
				HST_TAKE: st_ff <= HST_IDLE;
				default:  st_ff <= HST_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			dev_rd_ff <= RST_ZERO;
		end else if (st_ff == HST_TAKE) begin
			// device answer stands in the cycle after the link read strobe
			dev_rd_ff <= lnk.rdata;
		end
	end

	// ------------------------------------------------------------
	// interrupt status; set wins over write-one clear
	// ------------------------------------------------------------
	assign ev = {(st_ff == HST_TAKE) && (laddr_ff == REG_WAKE_SRC) && (|lnk.rdata),
	             (st_ff == HST_TAKE) || (st_ff == HST_IDLE && lwr_ff)};

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			stat_ff <= 2'h0;
			mask_ff <= 2'h0;
			o_irq   <= 1'b0;
		end else begin
			stat_ff <= (stat_ff & ~((i_wr && i_addr == REG_IRQ_STAT) ? i_wdata[1:0] : 2'h0)) | ev;
			if (i_wr && i_addr == REG_IRQ_MASK) begin
				mask_ff <= i_wdata[1:0];
			end
			o_irq <= |(stat_ff & mask_ff);
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rdata <= RST_ZERO;
		end else if (i_rd) begin
			case (i_addr)
				REG_IRQ_STAT:  o_rdata <= {30'h0, stat_ff};
				REG_IRQ_MASK:  o_rdata <= {30'h0, mask_ff};
				REG_DEV_CMD:   o_rdata <= {31'h0, st_ff != HST_IDLE};
				REG_DEV_RDATA: o_rdata <= dev_rd_ff;
				default:       o_rdata <= RST_ZERO;
			endcase
		end else begin
			o_rdata <= RST_ZERO;
		end
	end

endmodule
`default_nettype wire

// File: verif/swpc_chk.sv
// swpc_chk: concurrent checks on the link and the device power and pad outputs
// assumes: one clock; placed beside the link by the bench, no bind
`timescale 1ns/1ps
`default_nettype none
module swpc_chk
	import swpc_pkg::*;
#(
	parameter int unsigned CTL_W = swpc_pkg::CTL_W,
	parameter int unsigned SER_W = swpc_pkg::SER_W
) (
	input wire logic             i_clk,
	input wire logic             i_rst_n,
	input wire logic             wr,
	input wire logic             rd,
	input wire logic [3:0]       addr,
	input wire logic [31:0]      wdata,
	input wire logic [31:0]      rdata,
	input wire logic             i_fw_wr,
	input wire logic [3:0]       i_fw_addr,
	input wire logic [31:0]      i_fw_wdata,
	input wire logic             i_vbus_det,
	input wire logic             i_uart_cts,
	input wire logic             i_ctl_in,
	input wire logic             o_osc_en,
	input wire logic             o_pll_en,
	input wire logic             o_xcvr_en,
	input wire logic             o_core_pwr_en,
	input wire logic             o_cpu_pc_rst,
	input wire logic             o_standby,
	input wire logic             o_pad_hold,
	input wire logic [7:0]       o_pull_mode,
	input wire logic [7:0]       o_drive_sel,
	input wire logic [CTL_W-1:0] o_ctl_oe,
	input wire logic [CTL_W-1:0] o_ctl_out,
	input wire logic [SER_W-1:0] o_ser_oe
);
	// ------
	// helper logic
	// ------
	logic cts_pol_ff;
	logic wake_lvl;
	logic go_stby;
	// link wins over firmware, same as the device
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cts_pol_ff <= 1'b0;
		end else if (wr && addr == REG_CTRL) begin
			cts_pol_ff <= wdata[CTRL_CTS_POL];
		end else if (!wr && i_fw_wr && i_fw_addr == REG_CTRL) begin
			cts_pol_ff <= i_fw_wdata[CTRL_CTS_POL];
		end
	end
	assign wake_lvl = i_vbus_det || i_ctl_in || (i_uart_cts == cts_pol_ff);
	assign go_stby = o_osc_en && !o_pad_hold && !o_cpu_pc_rst
		&& ((wr && addr == REG_CTRL && wdata[CTRL_STANDBY])
		|| (!wr && i_fw_wr && i_fw_addr == REG_CTRL && i_fw_wdata[CTRL_STANDBY]));
	// ------
	// assertions
	// ------
	default clocking dc @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);
	sequence s_all_off;
		!o_osc_en && !o_pll_en && !o_xcvr_en && !o_core_pwr_en && o_pad_hold;
	endsequence
	sequence s_restart;
		o_cpu_pc_rst && o_osc_en && o_core_pwr_en && !o_standby && !o_pad_hold ##1 !o_cpu_pc_rst;
	endsequence
	a_entry_powers_down: assert property (go_stby |=> s_all_off ##1 o_standby)
		else $error("standby entry did not power down");
	a_standby_stays_off: assert property (o_standby |-> s_all_off)
		else $error("clock or core enabled in standby");
	a_wake_restarts: assert property (o_standby && wake_lvl |=> s_restart)
		else $error("wake did not restart the core");
	a_no_stray_wake: assert property (o_standby && !wake_lvl |=> o_standby)
		else $error("standby left without a wake source");
	a_pads_held: assert property (o_pad_hold ##1 o_pad_hold |-> $stable(o_ctl_oe)
		&& $stable(o_ctl_out) && $stable(o_ser_oe) && $stable(o_pull_mode))
		else $error("pad state changed while held");
	a_spare_line_off: assert property (!o_ctl_oe[CTL_SPARE] && !o_ctl_out[CTL_SPARE])
		else $error("spare control line used as gpio");
	a_pull_readback: assert property (rd && addr == REG_PULL |=> rdata[7:0] == o_pull_mode)
		else $error("pull readback differs from pads");
	a_drive_readback: assert property (rd && addr == REG_DRIVE |=> rdata[7:0] == o_drive_sel)
		else $error("drive readback differs from pads");
endmodule
`default_nettype wire

// File: verif/standby_wake_and_pad_control_tb_top.sv
// bench top: host port tasks, firmware port and wake pins around both ends
// assumes: one clock; the checker watches the link between the two ends
`timescale 1ns/1ps
`default_nettype none
module standby_wake_and_pad_control_tb_top;
	import swpc_pkg::*;
	logic        i_clk = 1'b0;
	logic        i_rst_n = 1'b0;
	logic        i_wr = 1'b0;
	logic        i_rd = 1'b0;
	logic        i_fw_wr = 1'b0;
	logic        i_vbus_det = 1'b0;
	logic        i_uart_cts = 1'b1;
	logic        i_ctl_in = 1'b0;
	logic [3:0]  i_addr = 4'h0;
	logic [31:0] i_wdata = 32'h0;
	logic [31:0] o_rdata, q;
	logic        o_irq, o_osc_en, o_pll_en, o_xcvr_en, o_core_pwr_en;
	logic        o_cpu_pc_rst, o_standby, o_pad_hold;
	logic [7:0]  o_pull_mode, o_drive_sel, o_ser_oe, o_ser_out;
	logic [15:0] o_ctl_oe, o_ctl_out;
	logic [15:0] cfg [6] = '{16'hffff, 16'hffff, 16'ha5a5, 16'h000f, 16'h00ff, 16'h00ff};
	int          n_mismatch = 0;
	int          check_count = 0;
	int          cyc = 0;
	swpc_if lnk_if ();
	swpc_device swpc_device_inst (
		.i_clk, .i_rst_n, .lnk(lnk_if.dev), .i_fw_wr, .i_fw_addr(REG_CTRL),
		.i_fw_wdata(32'h1), .i_vbus_det, .i_uart_cts, .i_ctl_in,
		.i_ctl_pin(16'h1234), .i_ser_pin(8'h5a), .o_osc_en, .o_pll_en, .o_xcvr_en,
		.o_core_pwr_en, .o_cpu_pc_rst, .o_standby, .o_pad_hold, .o_pull_mode,
		.o_drive_sel, .o_ctl_oe, .o_ctl_out, .o_ser_oe, .o_ser_out
	);
	swpc_host swpc_host_inst (
		.i_clk, .i_rst_n, .lnk(lnk_if.host), .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_irq
	);
	swpc_chk #(.CTL_W(CTL_W), .SER_W(SER_W)) swpc_chk_inst (
		.i_clk, .i_rst_n, .wr(lnk_if.wr), .rd(lnk_if.rd), .addr(lnk_if.addr),
		.wdata(lnk_if.wdata), .rdata(lnk_if.rdata), .i_fw_wr, .i_fw_addr(REG_CTRL),
		.i_fw_wdata(32'h1), .i_vbus_det, .i_uart_cts, .i_ctl_in, .o_osc_en, .o_pll_en,
		.o_xcvr_en, .o_core_pwr_en, .o_cpu_pc_rst, .o_standby, .o_pad_hold, .o_pull_mode,
		.o_drive_sel, .o_ctl_oe, .o_ctl_out, .o_ser_oe
	);
	// ------
	// clock, timeout, report
	// ------
	always #20 i_clk = ~i_clk;
	// the whole run needs well under a thousand cycles
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_mismatch++;
			finish_test();
		end
	end
	task automatic finish_test();
		$display("checks %0d, mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// ------
	// host port and device access
	// ------
	task automatic hwr(input logic [3:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask
	task automatic hrd(input logic [3:0] a, output logic [31:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 d = o_rdata;
	endtask
	// bounded poll, so a stuck busy bit cannot hang the run
	task automatic dev(input logic r, input logic [3:0] a, input logic [15:0] d);
		int n;
		n = 0;
		hwr(REG_DEV_CMD, {d, 7'h00, r, 4'h0, a});
		do begin
			hrd(REG_DEV_CMD, q);
			n++;
		end while (q[0] !== 1'b0 && n < 16);
		if (q[0] !== 1'b0) n_mismatch++;
		hrd(REG_DEV_RDATA, q);
	endtask
	// ------
	// tests
	// ------
	initial begin
		repeat (16) @(posedge i_clk);
		i_rst_n <= 1'b1;
		dev(1'b1, REG_WAKE_SRC, 16'h0);
		check(q, 32'h8);
		check({o_osc_en, o_pll_en, o_xcvr_en, o_core_pwr_en, o_standby, o_pad_hold}, 6'h3c);
		dev(1'b1, REG_PULL, 16'h0);
		check(q, 32'h55);
		check({o_pull_mode, o_ctl_oe, o_ser_oe}, 32'h55000000);
		$display("test reset done");
		dev(1'b0, REG_PULL, 16'h0091);
		dev(1'b0, REG_DRIVE, 16'h00e4);
		check(o_pull_mode, 8'h91);
		check(o_drive_sel, 8'he4);
		dev(1'b1, REG_DRIVE, 16'h0);
		check(q, 32'he4);
		for (int i = 0; i < 6; i++) begin
			dev(1'b0, REG_CTL_GPIO + 4'(i), cfg[i]);
		end
		check({o_ctl_oe, o_ctl_out}, 32'h7fff25a5);
		check({o_ser_oe, o_ser_out}, 16'h0f0f);
		dev(1'b1, REG_PIN_IN, 16'h0);
		check(q, 32'h005a1234);
		hwr(REG_IRQ_STAT, 32'h3);
		hwr(REG_IRQ_MASK, 32'h2);
		@(posedge i_clk);
		#1 check(o_irq, 1'b0);
		$display("test pads done");
		for (int k = 0; k < 3; k++) begin
			if (k == 1) begin
				@(posedge i_clk);
				i_fw_wr <= 1'b1;
				@(posedge i_clk);
				i_fw_wr <= 1'b0;
			end else begin
				dev(1'b0, REG_CTRL, (k == 2) ? 16'h3 : 16'h1);
			end
			repeat (4) @(posedge i_clk);
			#1 check({o_osc_en, o_pll_en, o_xcvr_en, o_core_pwr_en, o_standby, o_pad_hold}, 6'h03);
			check({o_pull_mode, o_ctl_out}, 24'h9125a5);
			@(posedge i_clk);
			case (k)
				0: i_vbus_det <= 1'b1;
				1: i_uart_cts <= 1'b0;
				default: i_ctl_in <= 1'b1;
			endcase
			@(posedge i_clk);
			#1 check({o_cpu_pc_rst, o_osc_en, o_core_pwr_en, o_standby, o_pad_hold}, 5'h1c);
			@(posedge i_clk);
			i_vbus_det <= 1'b0;
			i_ctl_in <= 1'b0;
			#1 check(o_cpu_pc_rst, 1'b0);
			dev(1'b1, REG_WAKE_SRC, 16'h0);
			check(q, 32'h1 << k);
			check(o_irq, 1'b1);
			hwr(REG_IRQ_STAT, 32'h3);
			@(posedge i_clk);
			#1 check(o_irq, 1'b0);
			$display("test wake %0d done", k);
		end
		dev(1'b1, REG_PULL, 16'h0);
		check(q, 32'h91);
		@(posedge i_clk);
		i_rst_n <= 1'b0;
		repeat (2) @(posedge i_clk);
		i_rst_n <= 1'b1;
		dev(1'b1, REG_PULL, 16'h0);
		check(q, 32'h55);
		$display("test mid-run reset done");
		finish_test();
	end
endmodule
`default_nettype wire
